// ===== verilog/pis_pkg.sv
package pis_pkg;

  // ----------------------------------------------------------------
  // Register offsets (Wishbone byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PIS_OFS_GIE     = 8'h00;
  localparam logic [7:0] PIS_OFS_EPIE    = 8'h04;
  localparam logic [7:0] PIS_OFS_PEND    = 8'h08;
  localparam logic [7:0] PIS_OFS_SNKIE   = 8'h0C;
  localparam logic [7:0] PIS_OFS_SNKPOL  = 8'h10;
  localparam logic [7:0] PIS_OFS_GPIE    = 8'h14;
  localparam logic [7:0] PIS_OFS_GPCFG   = 8'h18;
  localparam logic [7:0] PIS_OFS_SER     = 8'h1C;
  localparam logic [7:0] PIS_OFS_PINS    = 8'h20;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PIS_NUM_EP   = 5;
  localparam int PIS_SNK_W    = 8;
  localparam int PIS_GP_W     = 32;
  localparam int PIS_GP_PORTS = 4;
  localparam int PIS_NUM_SRC  = 8;

  // ----------------------------------------------------------------
  // Global enable bit positions and pending source index
  // ----------------------------------------------------------------
  localparam int PIS_SRC_EP0 = 0;
  localparam int PIS_SRC_SNK = 5;
  localparam int PIS_SRC_GP  = 6;
  localparam int PIS_SRC_SER = 7;
  localparam int PIS_GIE_PAP = 5;

  // ----------------------------------------------------------------
  // Serial control register field positions
  // ----------------------------------------------------------------
  localparam int PIS_SER_PROCEED  = 0;
  localparam int PIS_SER_MASTER   = 1;
  localparam int PIS_SER_ACK      = 2;
  localparam int PIS_SER_ADDR     = 3;
  localparam int PIS_SER_STOP     = 4;
  localparam int PIS_SER_ARBLOST  = 5;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  PIS_RST_BYTE = 8'h00;
  localparam logic [31:0] PIS_RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  PIS_CFG_PAP  = 2'h2;

  typedef enum logic [2:0]
  {
    PIS_EV_NONE     = 3'b000,
    PIS_EV_SLV_RX   = 3'b001,
    PIS_EV_SLV_STOP = 3'b010,
    PIS_EV_SLV_TX   = 3'b011,
    PIS_EV_MST_TX   = 3'b100,
    PIS_EV_MST_RX   = 3'b101,
    PIS_EV_ARB_LOST = 3'b110,
    PIS_EV_BUS_STOP = 3'b111
  } pis_ser_ev_e;

  typedef enum logic [1:0]
  {
    PIS_ARB_IDLE = 2'b00,
    PIS_ARB_WAIT = 2'b01
  } pis_arb_e;

endpackage : pis_pkg

// ===== verilog/pis_edge_if.sv
`timescale 1ns/100ps
interface pis_edge_if #(parameter int W = 8);
  logic [W-1:0] pins;
  logic [W-1:0] enable;
  logic [W-1:0] polarity;
  logic         block_all;
  logic         irq;
  logic [W-1:0] level;
  modport owner (output pins, output enable, output polarity, output block_all,
                 input irq, input level);
  modport unit  (input pins, input enable, input polarity, input block_all,
                 output irq, output level);
endinterface : pis_edge_if

// ===== verilog/pis_edge_unit.sv
`timescale 1ns/100ps
module pis_edge_unit #(parameter int W = 8)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  pis_edge_if.unit  eu
);
  import pis_pkg::*;

  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [W-1:0] sync3;
  logic [W-1:0] stable;
  logic [W-1:0] act;
  logic [W-1:0] act_d;
  logic         lock;
  logic [W-1:0] owner;

  // ----------------------------------------------------------------
  // Three stage synchroniser, change counts when stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1  <= '0;
      sync2  <= '0;
      sync3  <= '0;
      stable <= '0;
    end
    else if (ce_i)
    begin
      sync1 <= eu.pins;
      sync2 <= sync1;
      sync3 <= sync2;
      stable <= (sync2 & sync3) | (stable & (sync2 | sync3));
    end
  end

  // Polarity set means active high, so a rising edge triggers
  assign act       = ~(stable ^ eu.polarity) & eu.enable;
  assign eu.level  = stable;

  // ----------------------------------------------------------------
  // Edge detect and lockout until owner goes inactive or is disabled
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      act_d <= '0;
      lock  <= 1'b0;
      owner <= '0;
      eu.irq <= 1'b0;
    end
    else if (ce_i)
    begin
      act_d  <= act;
      eu.irq <= 1'b0;
      if (lock)
      begin
        if ((act & owner) == '0)
        begin
          lock <= 1'b0;
        end
      end
      else if (((act & ~act_d) != '0) && !eu.block_all)
      begin
        lock   <= 1'b1;
        owner  <= act & ~act_d;
        eu.irq <= 1'b1;
      end
    end
  end
endmodule : pis_edge_unit

// ===== verilog/pis_top.sv
`timescale 1ns/100ps
module pis_top
(
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  output logic                              wb_err_o,
  input  wire logic [pis_pkg::PIS_NUM_EP-1:0] ep_in_ack_i,
  input  wire logic [pis_pkg::PIS_NUM_EP-1:0] ep_out_ack_i,
  input  wire logic [pis_pkg::PIS_SNK_W-1:0]  sink_pins_i,
  input  wire logic [pis_pkg::PIS_GP_W-1:0]   gp_pins_i,
  input  wire logic                         pap_event_i,
  input  wire pis_pkg::pis_ser_ev_e         ser_event_i,
  input  wire logic                         ser_first_byte_i,
  input  wire logic                         ser_master_ack_i,
  input  wire logic [pis_pkg::PIS_NUM_SRC-1:0] service_i,
  output logic      [pis_pkg::PIS_NUM_SRC-1:0] irq_req_o,
  output logic      [pis_pkg::PIS_GP_W-1:0]    gp_cmos_en_o,
  output logic                              ser_stop_req_o
);
  import pis_pkg::*;

  logic [7:0]              gie;
  logic [7:0]              epie;
  logic [PIS_NUM_SRC-1:0]  pend;
  logic [PIS_SNK_W-1:0]    snk_ie;
  logic [PIS_SNK_W-1:0]    snk_pol;
  logic [PIS_GP_W-1:0]     gp_ie;
  logic [7:0]              gp_cfg;
  logic [7:0]              ser_ctl;
  logic                    pap_on;
  logic                    bus_wr;
  logic                    bus_rd;
  logic                    hit;
  logic [31:0]             next_rdata;
  logic [PIS_NUM_SRC-1:0]  src_ev;
  logic [PIS_GP_W-1:0]     gp_pol;
  pis_arb_e                arb_state;
  logic                    ser_irq;

  pis_edge_if #(.W(PIS_SNK_W)) snk_if ();
  pis_edge_if #(.W(PIS_GP_W))  gp_if ();

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic known(input logic [7:0] a);
    return (a == PIS_OFS_GIE) || (a == PIS_OFS_EPIE) || (a == PIS_OFS_PEND) ||
           (a == PIS_OFS_SNKIE) || (a == PIS_OFS_SNKPOL) || (a == PIS_OFS_GPIE) ||
           (a == PIS_OFS_GPCFG) || (a == PIS_OFS_SER) || (a == PIS_OFS_PINS);
  endfunction : known

  function automatic logic reg_wr(input logic wr, input logic [7:0] adr, input logic sel0,
                                  input logic [7:0] ofs);
    return wr && sel0 && (adr == ofs);
  endfunction : reg_wr

  // ----------------------------------------------------------------
  // Wishbone slave, one wait state answer
  // ----------------------------------------------------------------
  assign hit    = known(wb_adr_i);
  // Writes land at the edge that samples ack high
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && hit && wb_ack_o && ce_i;
  assign bus_rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ce_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= PIS_RST_WORD;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_rd && hit;
      wb_err_o <= bus_rd && !hit;
      if (bus_rd && hit && !wb_we_i)
      begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = PIS_RST_WORD;
    case (wb_adr_i)
      PIS_OFS_GIE:    next_rdata[7:0] = gie;
      PIS_OFS_EPIE:   next_rdata[4:0] = epie[4:0];
      PIS_OFS_PEND:   next_rdata[7:0] = pend;
      PIS_OFS_SNKIE:  next_rdata[7:0] = snk_ie;
      PIS_OFS_SNKPOL: next_rdata[7:0] = snk_pol;
      PIS_OFS_GPIE:   next_rdata      = gp_ie;
      PIS_OFS_GPCFG:  next_rdata[7:0] = gp_cfg;
      PIS_OFS_SER:    next_rdata[7:0] = ser_ctl;
      PIS_OFS_PINS:   next_rdata      = {gp_if.level[23:0], snk_if.level};
      default:        next_rdata      = PIS_RST_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // Enable and configuration registers, untouched by acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gie     <= PIS_RST_BYTE;
      epie    <= PIS_RST_BYTE;
      snk_ie  <= PIS_RST_BYTE;
      snk_pol <= PIS_RST_BYTE;
      gp_ie   <= PIS_RST_WORD;
      gp_cfg  <= PIS_RST_BYTE;
    end
    else if (bus_wr && wb_sel_i[0])
    begin
      case (wb_adr_i)
        PIS_OFS_GIE:    gie     <= wb_dat_i[7:0];
        PIS_OFS_EPIE:   epie    <= {3'h0, wb_dat_i[4:0]};
        PIS_OFS_SNKIE:  snk_ie  <= wb_dat_i[7:0];
        PIS_OFS_SNKPOL: snk_pol <= wb_dat_i[7:0];
        PIS_OFS_GPCFG:  gp_cfg  <= wb_dat_i[7:0];
        default:        gie     <= gie;
      endcase
    end
    // General enables honour every byte lane
    if (!rst_i && bus_wr && wb_adr_i == PIS_OFS_GPIE)
    begin
      gp_ie <= merge(gp_ie, wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // Pin edge units, one for sink port and one for general ports
  // ----------------------------------------------------------------
  // Parallel port owns the general vector when configured
  assign pap_on = (gp_cfg[1:0] == PIS_CFG_PAP);

  always_comb
  begin
    // One polarity bit per port of eight pins
    gp_pol = '0;
    for (int p = 0; p < PIS_GP_PORTS; p++)
    begin
      gp_pol[8*p +: 8] = {8{gp_cfg[2 + p]}};
    end
  end

  assign snk_if.pins      = sink_pins_i;
  assign snk_if.enable    = snk_ie;
  assign snk_if.polarity  = snk_pol;
  assign snk_if.block_all = 1'b0;
  assign gp_if.pins       = gp_pins_i;
  assign gp_if.enable     = gp_ie;
  assign gp_if.polarity   = gp_pol;
  assign gp_if.block_all  = pap_on;

  pis_edge_unit #(.W(PIS_SNK_W)) u_snk
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .eu    (snk_if.unit)
  );

  pis_edge_unit #(.W(PIS_GP_W)) u_gp
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .eu    (gp_if.unit)
  );

  // Pin enables keep steering CMOS drive even with parallel port on
  assign gp_cmos_en_o = gp_ie;

  // ----------------------------------------------------------------
  // Serial controller flags and arbitration wait
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ser_ctl   <= PIS_RST_BYTE;
      arb_state <= PIS_ARB_IDLE;
      ser_irq   <= 1'b0;
    end
    else if (ce_i)
    begin
      ser_irq <= 1'b0;
      if (reg_wr(bus_wr, wb_adr_i, wb_sel_i[0], PIS_OFS_SER))
      begin
        ser_ctl <= wb_dat_i[7:0];
      end
      case (ser_event_i)
        PIS_EV_SLV_RX:
        begin
          ser_ctl[PIS_SER_ADDR]    <= ser_first_byte_i;
          ser_ctl[PIS_SER_PROCEED] <= 1'b0;
          ser_irq                  <= 1'b1;
        end
        PIS_EV_SLV_STOP:
        begin
          if (ser_ctl[PIS_SER_ACK])
          begin
            ser_ctl[PIS_SER_STOP]    <= 1'b1;
            ser_ctl[PIS_SER_PROCEED] <= 1'b0;
            ser_irq                  <= 1'b1;
          end
        end
        PIS_EV_SLV_TX:
        begin
          ser_ctl[PIS_SER_ACK]     <= ser_master_ack_i;
          ser_ctl[PIS_SER_PROCEED] <= 1'b0;
          ser_irq                  <= 1'b1;
        end
        PIS_EV_MST_TX:
        begin
          ser_ctl[PIS_SER_PROCEED] <= 1'b0;
          ser_irq                  <= 1'b1;
        end
        PIS_EV_MST_RX:
        begin
          ser_irq <= 1'b1;
        end
        PIS_EV_ARB_LOST:
        begin
          ser_ctl[PIS_SER_MASTER]  <= 1'b0;
          ser_ctl[PIS_SER_ARBLOST] <= 1'b1;
          arb_state                <= PIS_ARB_WAIT;
        end
        PIS_EV_BUS_STOP:
        begin
          if (arb_state == PIS_ARB_WAIT)
          begin
            ser_irq   <= 1'b1;
            arb_state <= PIS_ARB_IDLE;
          end
        end
        default:
        begin
          arb_state <= arb_state;
        end
      endcase
    end
  end

  // Stop request when a write clears a set master select while arbitration is idle
  assign ser_stop_req_o = ser_ctl[PIS_SER_MASTER] && (arb_state == PIS_ARB_IDLE) &&
                          reg_wr(bus_wr, wb_adr_i, wb_sel_i[0], PIS_OFS_SER) &&
                          !wb_dat_i[PIS_SER_MASTER];

  // ----------------------------------------------------------------
  // Pending flip-flops, set wins over service, request gated by enables
  // ----------------------------------------------------------------
  always_comb
  begin
    src_ev = '0;
    src_ev[PIS_SRC_EP0 +: PIS_NUM_EP] = ep_in_ack_i | ep_out_ack_i;
    src_ev[PIS_SRC_SNK] = snk_if.irq;
    src_ev[PIS_SRC_GP]  = pap_on ? pap_event_i : gp_if.irq;
    src_ev[PIS_SRC_SER] = ser_irq;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend <= '0;
    end
    else if (ce_i)
    begin
      pend <= (pend & ~service_i) | src_ev;
    end
  end

  // ----------------------------------------------------------------
  // Request gating by enable registers
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_req_o = pend & gie;
    irq_req_o[PIS_SRC_EP0 +: PIS_NUM_EP] = pend[PIS_SRC_EP0 +: PIS_NUM_EP] &
                                           gie[PIS_SRC_EP0 +: PIS_NUM_EP] &
                                           epie[PIS_NUM_EP-1:0];
    irq_req_o[PIS_SRC_GP] = pend[PIS_SRC_GP] &
                            (pap_on ? gie[PIS_GIE_PAP] : gie[PIS_SRC_GP]);
  end
endmodule : pis_top

// ===== dv/pis_cpu_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// CPU side: services the lowest pending request, prompt or slow
// ------------------------------------------------------------
module pis_cpu_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] irq_i,
  output logic      [7:0] service_o
);
  logic [3:0] wait_cnt;

  always_ff @(posedge clk_i)
  begin
    service_o <= 8'h00;
    if (rst_i || !en_i || irq_i == 8'h00 || service_o != 8'h00)
      wait_cnt <= 4'h0;
    else if (wait_cnt >= (slow_i ? 4'h6 : 4'h1))
    begin
      wait_cnt  <= 4'h0;
      service_o <= irq_i & (~irq_i + 8'h01);
    end
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule : pis_cpu_model

// ===== dv/pis_top_checker.sv
`timescale 1ns/100ps
module pis_top_checker
  import pis_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 ce_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic                 wb_ack_o,
  input wire logic                 wb_err_o,
  input wire logic [4:0]           ep_in_ack_i,
  input wire logic [4:0]           ep_out_ack_i,
  input wire pis_pkg::pis_ser_ev_e ser_event_i,
  input wire logic [7:0]           service_i,
  input wire logic [7:0]           irq_req_o,
  input wire logic [31:0]          gp_cmos_en_o,
  input wire logic                 ser_stop_req_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
  endsequence

  AST_BUS_ANSWER: assert property (s_req |=> wb_ack_o || wb_err_o)
    else $error("Bus request not answered in the next cycle");
  AST_RESET_CLEAR: assert property ($fell(rst_i) |-> irq_req_o == 8'h00
    && gp_cmos_en_o == 32'h0000_0000)
    else $error("Request or enable not cleared by reset");
  AST_STOP_REQ: assert property (ser_stop_req_o |-> wb_cyc_i && wb_stb_i && wb_we_i
    && wb_adr_i == PIS_OFS_SER && !wb_dat_i[PIS_SER_MASTER])
    else $error("Stop request without a write clearing master select");
  AST_SERVICE_CLR: assert property (ce_i && service_i[PIS_SRC_SER]
    && ser_event_i == PIS_EV_NONE |=> !irq_req_o[PIS_SRC_SER])
    else $error("Serial request survives service");
  AST_ARB_WAIT: assert property (ce_i && ser_event_i == PIS_EV_ARB_LOST
    && !irq_req_o[PIS_SRC_SER] && !wb_cyc_i |=> !irq_req_o[PIS_SRC_SER])
    else $error("Arbitration loss raised request before stop");
  AST_EP_CAUSE: assert property ((irq_req_o[4:0] & ~$past(irq_req_o[4:0])) != 5'h00
    |-> $past(ep_in_ack_i | ep_out_ack_i) != 5'h00 || $past(wb_cyc_i && wb_we_i))
    else $error("Endpoint request without acknowledge");
  AST_PEND_HOLD: assert property (!(wb_cyc_i && wb_we_i) && service_i == 8'h00
    |=> ($past(irq_req_o) & ~irq_req_o) == 8'h00)
    else $error("Pending request dropped without service");
  AST_CMOS_STABLE: assert property ($changed(gp_cmos_en_o) |-> $past(rst_i)
    || $past(wb_cyc_i && wb_we_i && wb_adr_i == PIS_OFS_GPIE))
    else $error("Pin enables changed without a write");
endmodule : pis_top_checker

bind pis_top pis_top_checker pis_top_checker_inst (.*);

// ===== dv/pis_top_test.sv
`timescale 1ns/100ps
module pis_top_test;
  import pis_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wb_err_o;
  logic [4:0]  ep_in_ack_i = 5'h00;
  logic [4:0]  ep_out_ack_i = 5'h00;
  logic [7:0]  sink_pins_i = 8'h00;
  logic [31:0] gp_pins_i = 32'h0000_0000;
  logic        pap_event_i = 1'b0;
  pis_ser_ev_e ser_event_i = PIS_EV_NONE;
  logic        ser_first_byte_i = 1'b1;
  logic        ser_master_ack_i = 1'b0;
  logic [7:0]  service_i;
  logic [7:0]  irq_req_o;
  logic [31:0] gp_cmos_en_o;
  logic        ser_stop_req_o;
  logic        cpu_en = 1'b0;
  logic        cpu_slow = 1'b0;
  logic [31:0] rd;
  logic        err;
  logic        stp;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [7:0]  ser_mask [5] = '{8'h09, 8'h11, 8'h05, 8'h01, 8'h01};
  logic [7:0]  ser_val [5] = '{8'h08, 8'h10, 8'h00, 8'h00, 8'h01};

  always #2 clk_i = ~clk_i;

  pis_top pis_top_inst (.*);
  pis_cpu_model pis_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .en_i(cpu_en),
    .slow_i(cpu_slow), .irq_i(irq_req_o), .service_o(service_i));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic test_done;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    if (n >= 50)
      mismatches++;
    rd = wb_dat_o;
    err = wb_err_o;
    stp = ser_stop_req_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0000_0000);
    check(rd & m, e);
  endtask : rdc

  task automatic irq(input int b, input logic v);
    check({31'h0, irq_req_o[b]}, {31'h0, v});
  endtask : irq

  task automatic serve;
    cpu_slow <= ~cpu_slow;
    cpu_en   <= 1'b1;
    cyc(60);
    cpu_en   <= 1'b0;
    cyc(1);
  endtask : serve

  task automatic ser_pulse(input pis_ser_ev_e ev);
    @(posedge clk_i);
    ser_event_i <= ev;
    @(posedge clk_i);
    ser_event_i <= PIS_EV_NONE;
    cyc(2);
  endtask : ser_pulse

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    cyc(20);
    rst_i <= 1'b0;
    rdc(PIS_OFS_GIE, 32'h0000_00FF, 32'h0000_0000);
    rdc(PIS_OFS_EPIE, 32'h0000_00FF, 32'h0000_0000);
    wb_xfer(1'b1, 8'h24, 32'h0000_00FF);
    check({31'h0, err}, 32'h0000_0001);
    $display("Test reset done");
    wr(PIS_OFS_GIE, 32'h0000_00FF);
    for (int i = 0; i < PIS_NUM_EP; i++)
    begin
      @(posedge clk_i);
      if (i % 2 == 0)
        ep_in_ack_i[i] <= 1'b1;
      else
        ep_out_ack_i[i] <= 1'b1;
      @(posedge clk_i);
      ep_in_ack_i  <= 5'h00;
      ep_out_ack_i <= 5'h00;
      rdc(PIS_OFS_PEND, 32'h0000_001F, (32'h0000_0002 << i) - 32'h0000_0001);
      check({24'h0, irq_req_o}, 32'h0000_0000);
    end
    wr(PIS_OFS_EPIE, 32'h0000_001F);
    check({24'h0, irq_req_o}, 32'h0000_001F);
    serve();
    check({24'h0, irq_req_o}, 32'h0000_0000);
    $display("Test endpoints done");
    wr(PIS_OFS_SNKIE, 32'h0000_0001);
    for (int p = 0; p < 2; p++)
    begin
      wr(PIS_OFS_SNKPOL, 32'(p));
      sink_pins_i <= {7'h00, ~p[0]};
      cyc(10);
      serve();
      sink_pins_i <= {7'h00, p[0]};
      cyc(10);
      irq(PIS_SRC_SNK, 1'b1);
      serve();
    end
    $display("Test sink pins done");
    wr(PIS_OFS_GPCFG, 32'h0000_003C);
    wr(PIS_OFS_GPIE, 32'h0000_0101);
    check(gp_cmos_en_o, 32'h0000_0101);
    serve();
    gp_pins_i <= 32'h0000_0001;
    cyc(10);
    irq(PIS_SRC_GP, 1'b1);
    serve();
    gp_pins_i <= 32'h0000_0101;
    cyc(10);
    irq(PIS_SRC_GP, 1'b0);
    gp_pins_i <= 32'h0000_0000;
    cyc(10);
    gp_pins_i <= 32'h0000_0100;
    cyc(10);
    irq(PIS_SRC_GP, 1'b1);
    serve();
    rdc(PIS_OFS_GPIE, 32'hFFFF_FFFF, 32'h0000_0101);
    $display("Test general pins done");
    wr(PIS_OFS_GIE, 32'h0000_00DF);
    wr(PIS_OFS_GPCFG, 32'h0000_003E);
    gp_pins_i <= 32'h0000_0001;
    cyc(10);
    irq(PIS_SRC_GP, 1'b0);
    pap_event_i <= 1'b1;
    @(posedge clk_i);
    pap_event_i <= 1'b0;
    cyc(2);
    irq(PIS_SRC_GP, 1'b0);
    wr(PIS_OFS_GIE, 32'h0000_00FF);
    irq(PIS_SRC_GP, 1'b1);
    check(gp_cmos_en_o, 32'h0000_0101);
    serve();
    $display("Test parallel port done");
    for (int e = 1; e <= 5; e++)
    begin
      wr(PIS_OFS_SER, (e > 3) ? 32'h0000_0007 : 32'h0000_0005);
      check({31'h0, stp}, 32'h0000_0000);
      ser_pulse(pis_ser_ev_e'(e));
      irq(PIS_SRC_SER, 1'b1);
      rdc(PIS_OFS_SER, {24'h0, ser_mask[e-1]}, {24'h0, ser_val[e-1]});
      serve();
    end
    wr(PIS_OFS_SER, 32'h0000_0001);
    check({31'h0, stp}, 32'h0000_0001);
    ser_pulse(PIS_EV_SLV_STOP);
    irq(PIS_SRC_SER, 1'b0);
    rdc(PIS_OFS_SER, 32'h0000_0010, 32'h0000_0000);
    wr(PIS_OFS_SER, 32'h0000_0003);
    ser_pulse(PIS_EV_ARB_LOST);
    irq(PIS_SRC_SER, 1'b0);
    rdc(PIS_OFS_SER, 32'h0000_0022, 32'h0000_0020);
    ser_pulse(PIS_EV_BUS_STOP);
    irq(PIS_SRC_SER, 1'b1);
    serve();
    $display("Test serial done");
    rst_i <= 1'b1;
    cyc(20);
    rst_i <= 1'b0;
    rdc(PIS_OFS_GIE, 32'h0000_00FF, 32'h0000_0000);
    rdc(PIS_OFS_EPIE, 32'h0000_00FF, 32'h0000_0000);
    check({24'h0, irq_req_o}, 32'h0000_0000);
    $display("Test second reset done");
    ce_i <= 1'b0;
    @(posedge clk_i);
    ep_in_ack_i <= 5'h01;
    @(posedge clk_i);
    ep_in_ack_i <= 5'h00;
    cyc(2);
    ce_i <= 1'b1;
    rdc(PIS_OFS_PEND, 32'h0000_001F, 32'h0000_0000);
    $display("Test clock enable done");
    test_done();
  end
endmodule : pis_top_test
